// ===== logic/pdbc_board.sv
// Parity-checked DRAM board control: bus decode, refresh arbiter, parity capture, error port and APB setup.
// Notes on behaviour
// R1: Only the upper six address lines, or four with big chips, are compared when deciding a memory cycle is ours.
// R2: BHEN selects a word transfer, otherwise address bit 0 picks the byte.
// R3: Two sections, each with its own base on 256K or 1M boundary.
// R4: Each of four rows can be disabled; a disabled row never answers.
// R5: Refresh starts at a nominal interval of about thirteen microseconds.
// R6: A cycle to another board lets a pending refresh start at once.
// R7: Refresh is placed in gaps between our own accesses.
// R8: A parity error is latched and its chip group shown on three outputs.
// R9: The manual error reset input clears the latched error.
// R10: When enabled, a latched error drives the selected vectored interrupt line.
// R11: Reading the error port returns the failing chip group.
// R12: Writing the error port clears the error and drops the interrupt.
// R13: The error port decodes 8 or 16 address bits as configured.
// R14: Transfer acknowledge comes only after the data transfer is done.
// R15: An optional early acknowledge leads the normal one by a fixed time.
// R16: Read data by 205 ns, acknowledge by 230 ns; fast mode 155/175 ns.
// R17: Refresh request after 64 oscillator falls, forced after 56 more.
// R18: Early lead is 85, 145, 165 or 195 ns, on AACK or XACK; the code gives 80, 140, 160 or 180 ns, and in fast mode 80 or 120 ns.
// R19: A refresh falling due during our own cycle waits until it ends.
// R20: Each written byte stores a parity bit, checked on every read.
`timescale 1ns/1ps
`default_nettype none
`include "pdbc_regs.svh"
module pdbc_board #(
    parameter int MEM_AW = 6
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // APB register port
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // System bus pins
    input wire pdbc_pkg::pdbc_bus_t BUS_IN,
    output logic [15:0] DAT_O,
    output logic DAT_OE,
    output logic XACK_OE,
    output logic AACK_OE,
    output logic [7:0] INT_OE,
    // Indicators
    output logic [2:0] ERR_LED,
    output logic FORCED_REFRESH_N
);
    import pdbc_pkg::*;

    localparam int DEPTH = 4 << MEM_AW;
    // The pin synchroniser and the output flops cost cycles, so the counts give them back to keep pin timing.
    localparam int DATA_CYC = `PDBC_DATA_NS / `PDBC_CLK_NS - 3;
    localparam int XACK_CYC = `PDBC_XACK_NS / `PDBC_CLK_NS - 4;
    localparam int DATA_F_CYC = `PDBC_DATA_FAST_NS / `PDBC_CLK_NS - 3;
    localparam int XACK_F_CYC = `PDBC_XACK_FAST_NS / `PDBC_CLK_NS - 4;
    localparam int REF_CYC = (`PDBC_REFRESH_NS + `PDBC_CLK_NS - 1) / `PDBC_CLK_NS;
    localparam int IO_CYC = (`PDBC_IO_ACK_NS + `PDBC_CLK_NS - 1) / `PDBC_CLK_NS;

    // Early point of the acknowledge; a lead as long as the cycle or longer collapses to its first count.
    function automatic logic [5:0] early_at(input int xack_cyc, input logic [1:0] sel);
        int lead;
        lead = `PDBC_LEAD0_NS / `PDBC_CLK_NS;
        if (sel == 2'd1) begin
            lead = `PDBC_LEAD1_NS / `PDBC_CLK_NS;
        end else if (sel == 2'd2) begin
            lead = `PDBC_LEAD2_NS / `PDBC_CLK_NS;
        end else if (sel == 2'd3) begin
            lead = `PDBC_LEAD3_NS / `PDBC_CLK_NS;
        end
        return (xack_cyc > lead) ? 6'(xack_cyc - lead) : 6'd1;
    endfunction

    function automatic logic odd(input logic [7:0] b);
        return ^b;
    endfunction

    pdbc_bus_t meta_q;
    pdbc_bus_t bus_q;
    logic osc_old_q;
    pdbc_ctrl_t ctrl_q;
    logic [31:0] base_q;
    logic [15:0] ioadr_q;
    pdbc_state_t state_q;
    logic [5:0] cnt_q;
    logic [23:0] adr_q;
    logic word_q;
    logic wr_q;
    logic [17:0] mem_q [DEPTH];
    logic [6:0] tick_q;
    logic ref_req_q;
    logic forced_q;
    logic err_q;
    logic [2:0] group_q;
    logic xack_q;
    logic early_q;

    // Pins pass two flip-flops; only the second stage is read.
    always_ff @(posedge SYS_CLK) begin
        meta_q <= BUS_IN;
        bus_q <= meta_q;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            osc_old_q <= 1'b0;
        end else begin
            osc_old_q <= bus_q.osc;
        end
    end

    wire osc_fall = osc_old_q & ~bus_q.osc;
    wire mem_cmd = ~bus_q.mem_rd_n | ~bus_q.mem_wr_n;
    wire io_cmd = ~bus_q.io_rd_n | ~bus_q.io_wr_n;
    wire any_cmd = mem_cmd | io_cmd;

    // Section and row decode over address bits 23 down to 17.
    logic hit;
    logic [1:0] row;
    always_comb begin
        logic [5:0] top;
        logic [5:0] b0;
        logic [5:0] b1;
        top = bus_q.addr[23:18]; // R1
        b0 = base_q[5:0];
        b1 = base_q[`PDBC_BASE1_LSB +: 6];
        hit = 1'b0;
        row = 2'd0;
        if (ctrl_q.big_chips) begin
            row[0] = bus_q.addr[19];
            if (top[5:2] == b0[5:2]) begin // R3
                hit = 1'b1;
            end else if (top[5:2] == b1[5:2]) begin // R3
                hit = 1'b1;
                row[1] = 1'b1;
            end
        end else begin
            row[0] = bus_q.addr[17];
            if (top == b0) begin // R3
                hit = 1'b1;
            end else if (top == b1) begin // R3
                hit = 1'b1;
                row[1] = 1'b1;
            end
        end
        hit = hit & ctrl_q.row_en[row]; // R4
    end

    wire io_hit = ctrl_q.io16 ? (bus_q.addr[15:0] == ioadr_q) : (bus_q.addr[7:0] == ioadr_q[7:0]); // R13
    wire [MEM_AW+1:0] idx_q = {adr_q[23:22], adr_q[MEM_AW:1]};

    // Own memory cycles win over a mere request, but a forced refresh goes first once the board is idle.
    wire start_ref = (state_q == PDBC_IDLE) && (forced_q || (ref_req_q && !(mem_cmd && hit))); // R6 R7 R19
    wire start_mem = (state_q == PDBC_IDLE) && !forced_q && mem_cmd && hit;
    wire start_io = (state_q == PDBC_IDLE) && !forced_q && !(mem_cmd && hit) && !ref_req_q && io_cmd && io_hit;
    wire [5:0] data_at = ctrl_q.fast ? 6'(DATA_F_CYC) : 6'(DATA_CYC); // R16
    wire [5:0] xack_at = ctrl_q.fast ? 6'(XACK_F_CYC) : 6'(XACK_CYC); // R16
    wire [5:0] early_pt = ctrl_q.fast ? early_at(XACK_F_CYC, ctrl_q.lead_sel) : early_at(XACK_CYC, ctrl_q.lead_sel);
    wire data_pt = (state_q == PDBC_MEM) && (cnt_q == data_at);

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            state_q <= PDBC_IDLE;
            cnt_q <= 6'd0;
        end else begin
            case (state_q)
                PDBC_IDLE: begin
                    cnt_q <= 6'd1;
                    if (start_ref) begin
                        state_q <= PDBC_REF;
                    end else if (start_mem) begin
                        state_q <= PDBC_MEM;
                    end else if (start_io) begin
                        state_q <= PDBC_IO;
                    end
                end
                PDBC_MEM: begin
                    cnt_q <= cnt_q + 6'd1;
                    if (cnt_q == xack_at) begin
                        state_q <= PDBC_DONE;
                    end
                end
                PDBC_IO: begin
                    cnt_q <= cnt_q + 6'd1;
                    if (cnt_q == 6'(IO_CYC)) begin
                        state_q <= PDBC_DONE;
                    end
                end
                PDBC_REF: begin
                    cnt_q <= cnt_q + 6'd1;
                    if (cnt_q == 6'(REF_CYC)) begin
                        state_q <= PDBC_IDLE;
                    end
                end
                PDBC_DONE: begin
                    if (!any_cmd) begin
                        state_q <= PDBC_IDLE;
                    end
                end
                default: begin
                    state_q <= PDBC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            adr_q <= 24'h00_0000;
            word_q <= 1'b0;
            wr_q <= 1'b0;
        end else if (start_mem || start_io) begin
            adr_q <= {row, bus_q.addr[21:0]};
            word_q <= ~bus_q.bhen_n; // R2
            wr_q <= ~bus_q.mem_wr_n | ~bus_q.io_wr_n;
        end
    end

    // Storage keeps a parity bit beside each byte; the invert option lets software plant a bad one.
    always_ff @(posedge SYS_CLK) begin
        if (data_pt && wr_q) begin
            if (word_q || !adr_q[0]) begin // R2
                mem_q[idx_q][8:0] <= {odd(bus_q.data[7:0]) ^ ctrl_q.parity_invert, bus_q.data[7:0]}; // R20
            end
            if (word_q || adr_q[0]) begin // R2
                mem_q[idx_q][17:9] <= {odd(bus_q.data[15:8]) ^ ctrl_q.parity_invert, bus_q.data[15:8]}; // R20
            end
        end
    end

    wire [17:0] word_rd = mem_q[idx_q];
    wire bad_lo = (odd(word_rd[7:0]) != word_rd[8]) && (word_q || !adr_q[0]); // R20
    wire bad_hi = (odd(word_rd[16:9]) != word_rd[17]) && (word_q || adr_q[0]); // R20

    // Read data and acknowledge; data stays driven until the master drops its command.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            DAT_O <= 16'h0000;
            DAT_OE <= 1'b0;
        end else if (state_q == PDBC_IDLE) begin
            DAT_OE <= 1'b0;
        end else if (data_pt && !wr_q) begin
            DAT_O <= (word_q || !adr_q[0]) ? {word_rd[16:9], word_rd[7:0]} : {8'h00, word_rd[16:9]};
            DAT_OE <= 1'b1;
        end else if ((state_q == PDBC_IO) && (cnt_q == 6'd1) && !wr_q) begin
            DAT_O <= {12'h000, err_q, group_q}; // R11
            DAT_OE <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            xack_q <= 1'b0;
            early_q <= 1'b0;
        end else if (state_q == PDBC_IDLE) begin
            xack_q <= 1'b0;
            early_q <= 1'b0;
        end else begin
            if (((state_q == PDBC_MEM) && (cnt_q == xack_at)) || ((state_q == PDBC_IO) && (cnt_q == 6'(IO_CYC)))) begin
                xack_q <= 1'b1; // R14
            end
            if ((state_q == PDBC_MEM) && (cnt_q == early_pt) && ctrl_q.early_en) begin
                early_q <= 1'b1; // R15 R18
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            XACK_OE <= 1'b0;
            AACK_OE <= 1'b0;
        end else begin
            XACK_OE <= xack_q | (early_q & ctrl_q.early_ack_on_transfer_ack); // R18
            AACK_OE <= early_q & ctrl_q.early_ack_line_select; // R18
        end
    end

    // Refresh timer: the counter restarts whenever a refresh begins, which also cancels the forced one.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            tick_q <= 7'd0;
            ref_req_q <= 1'b0;
            forced_q <= 1'b0;
        end else if (start_ref) begin
            tick_q <= 7'd0;
            ref_req_q <= 1'b0;
            forced_q <= 1'b0;
        end else if (osc_fall) begin
            tick_q <= tick_q + 7'd1;
            if (!ref_req_q && (tick_q == 7'(`PDBC_REQ_COUNT - 1))) begin
                ref_req_q <= 1'b1; // R17 R5
                tick_q <= 7'd0;
            end else if (ref_req_q && (tick_q == 7'(`PDBC_FORCE_COUNT - 1))) begin
                forced_q <= 1'b1; // R17
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            FORCED_REFRESH_N <= 1'b1;
        end else begin
            FORCED_REFRESH_N <= ~forced_q;
        end
    end

    // Error latch: a new error in the clearing cycle survives the clear.
    wire err_set = data_pt && !wr_q && (bad_lo || bad_hi);
    wire err_clr = !bus_q.err_reset_n || ((state_q == PDBC_IO) && (cnt_q == 6'd1) && wr_q); // R9 R12
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            err_q <= 1'b0;
            group_q <= 3'b000;
        end else if (err_set) begin
            err_q <= 1'b1; // R8
            group_q <= {adr_q[23], bad_hi, bad_lo}; // R8
        end else if (err_clr) begin
            err_q <= 1'b0;
            group_q <= 3'b000;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ERR_LED <= 3'b000;
            INT_OE <= 8'h00;
        end else begin
            ERR_LED <= group_q; // R8
            INT_OE <= (err_q && ctrl_q.int_en) ? (8'h01 << ctrl_q.int_sel) : 8'h00; // R10 R12
        end
    end

    // APB slave: one wait state on every access, error on unmapped offsets.
    wire apb_go = PSEL && PENABLE && !PREADY;
    wire apb_wr = apb_go && PWRITE;
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctrl_q <= pdbc_ctrl_t'(17'(`PDBC_CTRL_RST));
            base_q <= `PDBC_BASE_RST;
            ioadr_q <= 16'(`PDBC_IOADR_RST);
        end else if (apb_wr) begin
            if (PADDR == `PDBC_CTRL_OFF) begin
                ctrl_q <= pdbc_ctrl_t'(PWDATA[16:0]);
            end else if (PADDR == `PDBC_BASE_OFF) begin
                base_q <= {18'h0_0000, PWDATA[13:8], 2'b00, PWDATA[5:0]};
            end else if (PADDR == `PDBC_IOADR_OFF) begin
                ioadr_q <= PWDATA[15:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= apb_go;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
            if (apb_go) begin
                if (PADDR == `PDBC_CTRL_OFF) begin
                    PRDATA <= {15'h0000, ctrl_q};
                end else if (PADDR == `PDBC_BASE_OFF) begin
                    PRDATA <= base_q;
                end else if (PADDR == `PDBC_IOADR_OFF) begin
                    PRDATA <= {16'h0000, ioadr_q};
                end else if (PADDR == `PDBC_STAT_OFF) begin
                    PRDATA <= {25'h000_0000, state_q != PDBC_IDLE, forced_q, ref_req_q, err_q, group_q};
                end else begin
                    PSLVERR <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== shared/pdbc_pkg.sv
// Types shared by the parity DRAM board control.
package pdbc_pkg;
    typedef enum logic [2:0] {
        PDBC_IDLE = 3'b000,
        PDBC_MEM = 3'b001,
        PDBC_REF = 3'b010,
        PDBC_IO = 3'b011,
        PDBC_DONE = 3'b100
    } pdbc_state_t;

    typedef struct packed {
        logic parity_invert;
        logic early_ack_on_transfer_ack;
        logic early_ack_line_select;
        logic early_en;
        logic [1:0] lead_sel;
        logic [2:0] int_sel;
        logic int_en;
        logic io16;
        logic [3:0] row_en;
        logic fast;
        logic big_chips;
    } pdbc_ctrl_t;

    typedef struct packed {
        logic mem_rd_n;
        logic mem_wr_n;
        logic io_rd_n;
        logic io_wr_n;
        logic bhen_n;
        logic err_reset_n;
        logic osc;
        logic [23:0] addr;
        logic [15:0] data;
    } pdbc_bus_t;
endpackage

// ===== shared/pdbc_regs.svh
// Register offsets, field positions, reset values and timing figures of the parity DRAM board control.
`ifndef PDBC_REGS_SVH
`define PDBC_REGS_SVH
`define PDBC_CTRL_OFF 12'h000
`define PDBC_BASE_OFF 12'h004
`define PDBC_IOADR_OFF 12'h008
`define PDBC_STAT_OFF 12'h00c
`define PDBC_CTRL_RST 32'h0000_003c
`define PDBC_BASE_RST 32'h0000_0100
`define PDBC_IOADR_RST 32'h0000_0000
`define PDBC_BASE1_LSB 8
`define PDBC_CLK_NS 10
`define PDBC_DATA_NS 205
`define PDBC_XACK_NS 230
`define PDBC_DATA_FAST_NS 155
`define PDBC_XACK_FAST_NS 175
`define PDBC_LEAD0_NS 85
`define PDBC_LEAD1_NS 145
`define PDBC_LEAD2_NS 165
`define PDBC_LEAD3_NS 195
`define PDBC_REFRESH_NS 200
`define PDBC_IO_ACK_NS 100
`define PDBC_REQ_COUNT 64
`define PDBC_FORCE_COUNT 56
`endif

// ===== verif/pdbc_board_checker.sv
// Port assertions for the parity DRAM board control.
`timescale 1ns/1ps
`default_nettype none
module pdbc_board_checker (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // System bus and indicators
    input wire pdbc_pkg::pdbc_bus_t BUS_IN,
    input wire logic DAT_OE,
    input wire logic XACK_OE,
    input wire logic AACK_OE,
    input wire logic [7:0] INT_OE,
    input wire logic [2:0] ERR_LED,
    input wire logic FORCED_REFRESH_N
);
    import pdbc_pkg::*;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    logic idle;
    assign idle = &{BUS_IN.mem_rd_n, BUS_IN.mem_wr_n, BUS_IN.io_rd_n, BUS_IN.io_wr_n};
    sequence apb_taken;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence cmd_done;
        !idle ##1 idle;
    endsequence
    apb_wait_a: assert property (apb_taken |=> PREADY) else $error("apb not answered");
    ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
    rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0) else $error("rdata without ready");
    slverr_ready_a: assert property (PSLVERR |-> PREADY) else $error("slverr without ready");
    xack_cmd_a: assert property ($rose(XACK_OE) |-> !idle) else $error("ack without command");
    read_data_a: assert property ($rose(XACK_OE) && !BUS_IN.mem_rd_n |-> DAT_OE && $past(DAT_OE, 2))
        else $error("ack before read data");
    xack_hold_a: assert property (XACK_OE && !idle |=> XACK_OE) else $error("ack dropped early");
    xack_drop_a: assert property (cmd_done |-> ##4 !DAT_OE ##1 !XACK_OE && !DAT_OE) else $error("ack stuck");
    aack_first_a: assert property ($rose(AACK_OE) |-> !XACK_OE) else $error("early ack late");
    int_err_a: assert property (INT_OE != 8'h00 |-> $onehot(INT_OE) && ERR_LED != 3'h0)
        else $error("interrupt without error");
    err_clear_a: assert property ((!BUS_IN.err_reset_n) [*5] |-> ERR_LED == 3'h0 && INT_OE == 8'h00)
        else $error("error not cleared");
    reset_out_a: assert property (disable iff (1'b0) !NRST |=> FORCED_REFRESH_N && !XACK_OE && INT_OE == 8'h00)
        else $error("outputs not reset");
endmodule
bind pdbc_board pdbc_board_checker chk_u (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BUS_IN(BUS_IN), .DAT_OE(DAT_OE), .XACK_OE(XACK_OE),
    .AACK_OE(AACK_OE), .INT_OE(INT_OE), .ERR_LED(ERR_LED), .FORCED_REFRESH_N(FORCED_REFRESH_N));
`default_nettype wire

// ===== verif/pdbc_board_tb_top.sv
// Self-checking testbench for the parity DRAM board control.
`timescale 1ns/1ps
`default_nettype none
module pdbc_board_tb_top;
    import pdbc_pkg::*;
    logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, dat_oe, xack_oe, aack_oe, forced_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] dat_o;
    logic [7:0] int_oe;
    logic [2:0] err_led;
    wire pdbc_bus_t bus;
    int mismatches, checks;
    pdbc_board dut_u (.SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUS_IN(bus),
        .DAT_O(dat_o), .DAT_OE(dat_oe), .XACK_OE(xack_oe), .AACK_OE(aack_oe), .INT_OE(int_oe),
        .ERR_LED(err_led), .FORCED_REFRESH_N(forced_n));
    pdbc_master_model master_u (.clk(sys_clk), .bus(bus), .dat_o(dat_o), .dat_oe(dat_oe), .xack_oe(xack_oe),
        .aack_oe(aack_oe));
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        checks++;
        if (got != exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk32(rd, exp);
        chk32({31'h0, err}, {31'h0, experr});
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, v, rd, err);
    endtask
    task automatic bus_chk(input logic [1:0] kind, input logic [23:0] a, input logic bh, input logic [15:0] d,
                           input logic [15:0] expq, input logic expok);
        logic [15:0] q;
        logic ok;
        int gap;
        master_u.cycle(kind, a, bh, d, q, ok, gap);
        chk32({31'h0, ok}, {31'h0, expok});
        if (expok && !kind[0]) chk32({16'h0, q}, {16'h0, expq});
    endtask
    task automatic t_regs();
        reg_rd(12'h000, 32'h0000_003c, 1'b0);
        reg_rd(12'h004, 32'h0000_0100, 1'b0);
        reg_rd(12'h008, 32'h0000_0000, 1'b0);
        reg_rd(12'h010, 32'h0000_0000, 1'b1);
        reg_wr(12'h008, 32'h0000_1234);
        reg_rd(12'h008, 32'h0000_1234, 1'b0);
    endtask
    task automatic t_io16();
        reg_wr(12'h000, 32'h0000_007c);
        bus_chk(2'd2, 24'h005634, 1'b0, 16'h0, 16'h0, 1'b0);
        bus_chk(2'd2, 24'h001234, 1'b0, 16'h0, 16'h0, 1'b1);
        reg_wr(12'h000, 32'h0000_003c);
        bus_chk(2'd2, 24'h005634, 1'b0, 16'h0, 16'h0, 1'b1);
    endtask
    task automatic t_mem();
        bus_chk(2'd1, 24'h000010, 1'b0, 16'ha53c, 16'h0, 1'b1);
        bus_chk(2'd1, 24'h000011, 1'b1, 16'h7e7e, 16'h0, 1'b1);
        bus_chk(2'd0, 24'h000010, 1'b0, 16'h0, 16'h7e3c, 1'b1);
        bus_chk(2'd0, 24'h000010, 1'b1, 16'h0, 16'h7e3c, 1'b1);
        chk32({29'h0, err_led}, 32'h0);
    endtask
    task automatic t_decode();
        bus_chk(2'd1, 24'h800010, 1'b0, 16'h1111, 16'h0, 1'b0);
        bus_chk(2'd1, 24'h040010, 1'b0, 16'h2222, 16'h0, 1'b1);
        bus_chk(2'd0, 24'h040010, 1'b0, 16'h0, 16'h2222, 1'b1);
        bus_chk(2'd0, 24'h000010, 1'b0, 16'h0, 16'h7e3c, 1'b1);
        reg_wr(12'h000, 32'h0000_0038);
        bus_chk(2'd0, 24'h000010, 1'b0, 16'h0, 16'h0, 1'b0);
        bus_chk(2'd0, 24'h040010, 1'b0, 16'h0, 16'h2222, 1'b1);
        reg_wr(12'h000, 32'h0000_003c);
    endtask
    task automatic t_parity();
        reg_wr(12'h000, 32'h0001_03bc);
        bus_chk(2'd1, 24'h000020, 1'b0, 16'h1234, 16'h0, 1'b1);
        reg_wr(12'h000, 32'h0000_03bc);
        bus_chk(2'd0, 24'h000020, 1'b0, 16'h0, 16'h1234, 1'b1);
        chk32({21'h0, int_oe, err_led}, 32'h0000_0043);
        bus_chk(2'd2, 24'h000034, 1'b0, 16'h0, 16'h000b, 1'b1);
        bus_chk(2'd3, 24'h000034, 1'b0, 16'h0, 16'h0, 1'b1);
        chk32({21'h0, int_oe, err_led}, 32'h0);
        bus_chk(2'd0, 24'h000020, 1'b0, 16'h0, 16'h1234, 1'b1);
        master_u.press_reset();
        chk32({21'h0, int_oe, err_led}, 32'h0);
    endtask
    task automatic t_early();
        logic [15:0] q;
        logic ok;
        int gap;
        // The pin pipeline caps the longest lead one cycle short of its nominal figure.
        int lead[4] = '{8, 14, 16, 18};
        for (int l = 0; l < 4; l++) begin
            reg_wr(12'h000, 32'h0000_603c | (l << 11));
            master_u.cycle(2'd0, 24'h000010, 1'b0, 16'h0, q, ok, gap);
            chkn(gap, lead[l]);
        end
        reg_wr(12'h000, 32'h0000_603e);
        master_u.cycle(2'd0, 24'h000010, 1'b0, 16'h0, q, ok, gap);
        chkn(gap, lead[0]);
        chk32({16'h0, q}, 32'h0000_7e3c);
        reg_wr(12'h000, 32'h0000_003c);
    endtask
    task automatic t_refresh();
        master_u.hold(24'h800010, 2600);
        chk32({31'h0, forced_n}, 32'h1);
        master_u.release_cmd();
        master_u.hold(24'h000010, 2600);
        chk32({31'h0, forced_n}, 32'h0);
        master_u.release_cmd();
        chk32({31'h0, forced_n}, 32'h1);
    endtask
    task automatic conclude();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        mismatches = 0;
        checks = 0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_io16();
        t_mem();
        t_decode();
        t_parity();
        t_early();
        t_refresh();
        conclude();
    end
    // The whole sequence needs well under half of this span.
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
endmodule
`default_nettype wire

// ===== verif/pdbc_master_model.sv
// Bus master model: memory and I/O cycles, error button and free-running refresh crystal.
`timescale 1ns/1ps
`default_nettype none
module pdbc_master_model (
    // Clock
    input wire logic clk,
    // Board pins
    output wire pdbc_pkg::pdbc_bus_t bus,
    input wire logic [15:0] dat_o,
    input wire logic dat_oe,
    input wire logic xack_oe,
    input wire logic aack_oe
);
    import pdbc_pkg::*;
    logic [3:0] cmd_n;
    logic bhen_n, err_n, osc;
    logic [23:0] addr;
    logic [15:0] data;
    assign bus = {cmd_n, bhen_n, err_n, osc, addr, data};
    initial begin
        cmd_n = 4'hf;
        bhen_n = 1'b1;
        err_n = 1'b1;
        osc = 1'b0;
        addr = 24'h0;
        data = 16'h0;
    end
    // The crystal runs free, so refresh can collide with any cycle.
    always #101.725 osc = ~osc;
    // Kind: 0 memory read, 1 memory write, 2 port read, 3 port write.
    task automatic cycle(input logic [1:0] kind, input logic [23:0] a, input logic bh, input logic [15:0] d,
                         output logic [15:0] q, output logic ok, output int gap);
        int n;
        int ta;
        n = 0;
        ta = -1;
        ok = 1'b0;
        q = 16'h0;
        @(posedge clk);
        addr <= a;
        bhen_n <= bh;
        data <= kind[0] ? d : ~data;
        repeat (5) @(posedge clk);
        cmd_n <= ~(4'b1000 >> kind);
        while (n < 80 && !ok) begin
            @(posedge clk);
            n++;
            if (aack_oe === 1'b1 && ta < 0) ta = n;
            if (xack_oe === 1'b1) begin
                ok = 1'b1;
                q = dat_oe ? dat_o : 16'h0;
            end
        end
        gap = (ta < 0) ? -1 : n - ta;
        cmd_n <= 4'hf;
        data <= ~data;
        repeat (6) @(posedge clk);
    endtask
    task automatic press_reset();
        @(posedge clk);
        err_n <= 1'b0;
        repeat (6) @(posedge clk);
        err_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // Holds a word read long past its acknowledge, as a slow master would.
    task automatic hold(input logic [23:0] a, input int cycles);
        @(posedge clk);
        addr <= a;
        bhen_n <= 1'b0;
        repeat (5) @(posedge clk);
        cmd_n <= 4'b0111;
        repeat (cycles) @(posedge clk);
    endtask
    task automatic release_cmd();
        cmd_n <= 4'hf;
        repeat (40) @(posedge clk);
    endtask
endmodule
`default_nettype wire
